// ---- design/i2c_link_if.sv ----
// the two-wire link between bus master and register slave
// both lines are open drain; a pull-up is modelled by the and below
interface i2c_link_if;
  logic sclOut; // master clock drive value
  logic sclOe; // master drives the clock line
  logic hostSdaOut; // master data drive value
  logic hostSdaOe; // master drives the data line
  logic devSdaOut; // slave data drive value
  logic devSdaOe; // slave drives the data line
  logic scl; // resolved clock level
  logic sda; // resolved data level
  // wired-and of all drivers, high when nobody pulls low
  assign scl = ~(sclOe & ~sclOut);
  assign sda = ~(hostSdaOe & ~hostSdaOut) & ~(devSdaOe & ~devSdaOut);
  modport device (input scl, input sda, output devSdaOut, output devSdaOe);
  modport host (input scl, input sda, output sclOut, output sclOe,
    output hostSdaOut, output hostSdaOe);
endinterface

// ---- design/i2c_reg_host_end.sv ----
// bus master end: single register write, read, and read from last index
// assumes the slave answers within a quarter of the serial clock
module i2c_reg_host_end
(
  input wire logic clk,
  input wire logic rst_n,
  i2c_link_if.host link,
  input wire logic cmdValid,
  input wire i2c_reg_pkg::host_cmd_t cmdKind,
  input wire logic [15:0] cmdAddr,
  input wire logic [15:0] cmdWData,
  input wire logic targetIdSel,
  output logic cmdReady,
  output logic done,
  output logic nackErr,
  output logic [15:0] rdData
);
  import i2c_reg_pkg::*;

  host_state_t state_q; // sequencer state
  host_cmd_t kind_q; // latched command
  logic [15:0] addr_q; // latched register index
  logic [15:0] wData_q; // latched write word
  logic [7:0] id_q; // target identifier, write form
  logic [7:0] tick_q; // quarter-period divider
  logic [1:0] qtr_q; // quarter within a bit
  logic [3:0] bitNo_q; // bit 0..7, 8 is the ack slot
  logic [2:0] byteNo_q; // byte slot in the frame
  logic [7:0] rx_q; // received byte
  logic [7:0] rdHi_q; // first received byte
  logic sclOe_q; // hold clock low
  logic sdaOe_q; // hold data low
  logic sdaS; // synchronised data line
  logic tick; // quarter boundary
  logic rxMode; // this byte comes from the slave
  logic [2:0] lastByte; // final byte slot of the frame
  logic [7:0] curByte; // byte being sent

  i2c_sync2 uSdaSync (.clk(clk), .d(link.sda), .q(sdaS));

  // open drain: drive value is always low
  assign link.sclOut = 1'b0;
  assign link.hostSdaOut = 1'b0;
  assign link.sclOe = sclOe_q;
  assign link.hostSdaOe = sdaOe_q;
  assign tick = (tick_q == QUARTER_LAST);
  assign rxMode = (kind_q != CMD_WRITE) && (byteNo_q >= 3'd4);
  assign lastByte = (kind_q == CMD_WRITE) ? 3'd4 : 3'd5;

  // byte slots: id, index hi, index lo, then data or read id
  always_comb
  begin
    unique case (byteNo_q)
      3'd0: curByte = {id_q[7:1], 1'b0}; // R3
      3'd1: curByte = addr_q[15:8]; // R15
      3'd2: curByte = addr_q[7:0]; // R15
      3'd3: curByte = (kind_q == CMD_WRITE) ? wData_q[15:8] : {id_q[7:1], 1'b1}; // R3
      default: curByte = wData_q[7:0];
    endcase
  end

  // quarter-period divider, runs only while a frame is active
  always_ff @(posedge clk)
  begin
    if (!rst_n || state_q == H_IDLE || tick)
      tick_q <= '0;
    else
      tick_q <= tick_q + 8'd1;
  end

  // frame sequencer
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      state_q <= H_IDLE;
      kind_q <= CMD_WRITE;
      addr_q <= '0;
      wData_q <= '0;
      id_q <= ID_SEL_LOW;
      qtr_q <= '0;
      bitNo_q <= '0;
      byteNo_q <= '0;
      rx_q <= '0;
      rdHi_q <= '0;
      sclOe_q <= 1'b0;
      sdaOe_q <= 1'b0;
      cmdReady <= 1'b0;
      done <= 1'b0;
      nackErr <= 1'b0;
      rdData <= '0;
    end
    else
    begin
      done <= 1'b0;
      if (state_q == H_IDLE)
      begin
        cmdReady <= 1'b1;
        if (cmdValid && cmdReady)
        begin
          state_q <= H_START;
          cmdReady <= 1'b0;
          nackErr <= 1'b0;
          kind_q <= cmdKind;
          addr_q <= cmdAddr;
          wData_q <= cmdWData;
          id_q <= targetIdSel ? ID_SEL_HIGH : ID_SEL_LOW;
          qtr_q <= '0;
          bitNo_q <= '0;
          // read from last index skips straight to the read id
          byteNo_q <= (cmdKind == CMD_READ_LAST) ? 3'd3 : 3'd0; // R10
        end
      end
      else if (tick)
      begin
        qtr_q <= qtr_q + 2'd1;
        unique case (state_q)
          H_START:
          begin
            // release data, clock high, data falls, clock low
            unique case (qtr_q)
              2'd0: sdaOe_q <= 1'b0;
              2'd1: sclOe_q <= 1'b0;
              2'd2: sdaOe_q <= 1'b1; // R4
              2'd3:
              begin
                sclOe_q <= 1'b1;
                state_q <= H_BIT;
              end
            endcase
          end
          H_BIT:
          begin
            unique case (qtr_q)
              2'd0:
              begin
                // data changes only while the clock is low
                if (bitNo_q != 4'd8)
                  sdaOe_q <= ~rxMode & ~curByte[3'd7 - bitNo_q[2:0]]; // R4
                else
                  sdaOe_q <= rxMode & (byteNo_q != lastByte); // R16
              end
              2'd1: sclOe_q <= 1'b0;
              2'd2:
              begin
                if (bitNo_q != 4'd8)
                  rx_q <= {rx_q[6:0], sdaS};
                else if (!rxMode && sdaS)
                begin
                  // slave refused a byte: abort to the last stop quarter, both lines left released, no stop condition driven
                  nackErr <= 1'b1; // R15
                  state_q <= H_STOP;
                end
              end
              2'd3:
              begin
                sclOe_q <= 1'b1;
                bitNo_q <= (bitNo_q == 4'd8) ? 4'd0 : bitNo_q + 4'd1;
                if (bitNo_q == 4'd8)
                begin
                  if (byteNo_q == 3'd4 && rxMode)
                    rdHi_q <= rx_q; // R15
                  if (byteNo_q == lastByte)
                  begin
                    state_q <= H_STOP; // R7
                    if (rxMode)
                      rdData <= {rdHi_q, rx_q};
                  end
                  else if (kind_q == CMD_READ && byteNo_q == 3'd2)
                    state_q <= H_START; // R16
                  byteNo_q <= byteNo_q + 3'd1;
                end
              end
            endcase
          end
          H_STOP:
          begin
            // data low, clock high, data rises
            unique case (qtr_q)
              2'd0: sdaOe_q <= 1'b1;
              2'd1: sclOe_q <= 1'b0;
              2'd2: sdaOe_q <= 1'b0; // R7
              2'd3:
              begin
                state_q <= H_IDLE;
                done <= 1'b1;
              end
            endcase
          end
          default: state_q <= H_IDLE;
        endcase
      end
    end
  end
endmodule

// ---- design/i2c_reg_pkg.sv ----
// shared constants for the two-wire register port: ids, map, timing
// assumes both ends and the bench import this package
package i2c_reg_pkg;
  // bus identifiers picked by the id-select pin level
  localparam logic [7:0] ID_SEL_LOW = 8'h34;
  localparam logic [7:0] ID_SEL_HIGH = 8'h36;
  // register indices (16-bit index space)
  localparam logic [15:0] REG_ID = 16'h0000;
  localparam logic [15:0] REG_STATUS = 16'h0002;
  localparam logic [15:0] REG_CP_CONFIG = 16'h0101;
  localparam logic [15:0] REG_PULL_CTRL = 16'h0721;
  // field positions
  localparam int AUTO_INC_BIT = 2;
  localparam int PULLDOWN_BIT = 8;
  localparam int CORE_ALIVE_BIT = 0;
  // reset values
  localparam logic [15:0] CP_CONFIG_RST = 16'h0004;
  localparam logic [15:0] PULL_CTRL_RST = 16'h0150;
  // identification word, value is arbitrary
  localparam logic [15:0] DEVICE_ID_WORD = 16'h5A01;
  // host timing: core clock and serial clock rates
  localparam int CLK_HZ = 20000000;
  localparam int SCL_HZ = 100000;
  localparam int QUARTER_CYC = CLK_HZ / (4 * SCL_HZ);
  localparam logic [7:0] QUARTER_LAST = 8'(QUARTER_CYC - 1);
  // core-clock activity toggle divider and link-side timeout
  localparam int ALIVE_DIV_W = 3;
  localparam logic [3:0] ALIVE_TIMEOUT = 4'hF;
  // device serial engine states
  typedef enum logic [2:0]
  {
    ST_IDLE = 3'b000,
    ST_RX = 3'b001,
    ST_RXACK = 3'b010,
    ST_TX = 3'b011,
    ST_TXACK = 3'b100,
    ST_TXNEXT = 3'b101
  } dev_state_t;
  // which byte of the frame the device is receiving
  typedef enum logic [2:0]
  {
    PH_ID = 3'b000,
    PH_AHI = 3'b001,
    PH_ALO = 3'b010,
    PH_DHI = 3'b011,
    PH_DLO = 3'b100
  } dev_phase_t;
  // host sequencer states
  typedef enum logic [1:0]
  {
    H_IDLE = 2'b00,
    H_START = 2'b01,
    H_BIT = 2'b10,
    H_STOP = 2'b11
  } host_state_t;
  // host command kinds
  typedef enum logic [1:0]
  {
    CMD_WRITE = 2'b00,
    CMD_READ = 2'b01,
    CMD_READ_LAST = 2'b10
  } host_cmd_t;
endpackage

// ---- design/i2c_reg_slave_end.sv ----
// register slave end of the two-wire control port
// assumes linkClk free-runs several times faster than the serial clock
// Notes on behaviour
// [R1] slave only; data line pulled low or released
// [R2] id-select pin low gives 34h, high 36h
// [R3] id byte bit 0: one read, zero write
// [R4] start condition, then id shifted msb first
// [R5] matching id is acknowledged by pulling low
// [R6] foreign id: go idle until next start
// [R7] stop condition ends frame, device goes idle
// [R8] stray start or stop abandons the transfer
// [R9] single and stepping multi-register reads, writes
// [R10] read without index continues from last index
// [R11] index stepping bit 2 of 0101h, reset one
// [R12] every register reads back, id and status
// [R13] access without core clock; updates resynchronised
// [R14] id-select pulldown bit 8 of 0721h, reset on
// [R15] index then data, msb byte first, all acked
// [R16] master reads: index, restart, nack last byte
module i2c_reg_slave_end
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic linkClk,
  i2c_link_if.device link,
  input wire logic idSelect,
  output logic autoIncEn,
  output logic idSelectPulldownEnable
);
  import i2c_reg_pkg::*;

  logic linkRstN; // reset as seen in the link domain
  logic sclS; // synchronised clock line
  logic sdaS; // synchronised data line
  logic idSelS; // synchronised id-select pin
  logic aliveS; // synchronised core activity toggle
  logic autoIncS; // stepping bit as seen by the core clock
  logic sclP_q; // previous clock sample
  logic sdaP_q; // previous data sample
  logic aliveP_q; // previous toggle sample
  logic [3:0] aliveCnt_q; // link cycles since the toggle last moved
  logic [ALIVE_DIV_W-1:0] aliveDiv_q; // core-side divider
  logic aliveTgl_q; // core-side activity toggle
  dev_state_t state_q; // serial engine state
  dev_phase_t phase_q; // byte being received
  logic [3:0] bitCnt_q; // bits shifted in this byte
  logic [7:0] rxShift_q; // incoming byte
  logic [7:0] txShift_q; // outgoing byte
  logic sdaOe_q; // pull data line low
  logic isRead_q; // direction from the id byte
  logic txLo_q; // low byte of the word is on the wire
  logic [7:0] addrHi_q; // index high byte
  logic [7:0] dataHi_q; // data high byte
  logic [15:0] ptr_q; // register index, survives between frames
  logic [15:0] cpConfig_q; // control port configuration
  logic [15:0] pullCtrl_q; // pin pull control
  logic [15:0] rdWord; // word at the current index
  logic [7:0] ownId; // our bus identifier
  logic sclRise; // clock line rose
  logic sclFall; // clock line fell
  logic startCond; // data fell while clock high
  logic stopCond; // data rose while clock high
  logic byteDone; // eighth bit in, clock now falling
  logic commit; // a full data word has arrived
  logic coreAlive; // core clock seen running

  // the link side is reset from the core reset pin through a synchroniser
  i2c_sync2 uRstSync (.clk(linkClk), .d(rst_n), .q(linkRstN));
  i2c_sync2 uSclSync (.clk(linkClk), .d(link.scl), .q(sclS));
  i2c_sync2 uSdaSync (.clk(linkClk), .d(link.sda), .q(sdaS));
  i2c_sync2 uIdSync (.clk(linkClk), .d(idSelect), .q(idSelS));
  i2c_sync2 uAliveSync (.clk(linkClk), .d(aliveTgl_q), .q(aliveS));
  i2c_sync2 uAutoSync (.clk(clk), .d(cpConfig_q[AUTO_INC_BIT]), .q(autoIncS));

  // data line is only ever pulled low, never driven high
  assign link.devSdaOut = 1'b0; // R1
  assign link.devSdaOe = sdaOe_q; // R1

  // edge and condition detection on the synchronised lines
  assign sclRise = sclS & ~sclP_q;
  assign sclFall = ~sclS & sclP_q;
  assign startCond = sclS & sclP_q & sdaP_q & ~sdaS; // R4 R8
  assign stopCond = sclS & sclP_q & ~sdaP_q & sdaS; // R7 R8
  assign ownId = idSelS ? ID_SEL_HIGH : ID_SEL_LOW; // R2
  assign byteDone = (state_q == ST_RX) & sclFall & (bitCnt_q == 4'd8);
  assign commit = byteDone & (phase_q == PH_DLO);
  assign coreAlive = (aliveCnt_q != ALIVE_TIMEOUT);

  // core clock: slow toggle that proves the clock runs
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      aliveDiv_q <= '0;
      aliveTgl_q <= 1'b0;
    end
    else
    begin
      aliveDiv_q <= aliveDiv_q + ALIVE_DIV_W'(1);
      if (&aliveDiv_q)
        aliveTgl_q <= ~aliveTgl_q;
    end
  end

  // core clock: stepping enable reaches core logic through a synchroniser
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      autoIncEn <= CP_CONFIG_RST[AUTO_INC_BIT];
    else
      autoIncEn <= autoIncS; // R13
  end

  // link clock: previous samples and core activity watchdog
  always_ff @(posedge linkClk)
  begin
    if (!linkRstN)
    begin
      sclP_q <= 1'b1;
      sdaP_q <= 1'b1;
      aliveP_q <= 1'b0;
      aliveCnt_q <= ALIVE_TIMEOUT;
    end
    else
    begin
      sclP_q <= sclS;
      sdaP_q <= sdaS;
      aliveP_q <= aliveS;
      // saturates when the core clock stops, so status shows it
      if (aliveS != aliveP_q)
        aliveCnt_q <= '0;
      else if (aliveCnt_q != ALIVE_TIMEOUT)
        aliveCnt_q <= aliveCnt_q + 4'd1;
    end
  end

  // read multiplexer: every register can be read back
  always_comb
  begin
    unique case (ptr_q)
      REG_ID: rdWord = DEVICE_ID_WORD; // R12
      REG_STATUS: rdWord = {15'h0000, coreAlive}; // R12
      REG_CP_CONFIG: rdWord = cpConfig_q; // R12
      REG_PULL_CTRL: rdWord = pullCtrl_q; // R12
      default: rdWord = 16'h0000;
    endcase
  end

  // register file lives on the link clock so it works with no core clock
  always_ff @(posedge linkClk)
  begin
    if (!linkRstN)
    begin
      cpConfig_q <= CP_CONFIG_RST; // R11
      pullCtrl_q <= PULL_CTRL_RST; // R14
    end
    else if (commit)
    begin
      if (ptr_q == REG_CP_CONFIG)
        cpConfig_q <= {dataHi_q, rxShift_q}; // R11
      if (ptr_q == REG_PULL_CTRL)
        pullCtrl_q <= {dataHi_q, rxShift_q}; // R14
    end
  end

  // pad control follows the pull register directly
  always_ff @(posedge linkClk)
  begin
    if (!linkRstN)
      idSelectPulldownEnable <= PULL_CTRL_RST[PULLDOWN_BIT];
    else
      idSelectPulldownEnable <= pullCtrl_q[PULLDOWN_BIT]; // R14
  end

  // register index: loaded from the frame, stepped after each word
  always_ff @(posedge linkClk)
  begin
    if (!linkRstN)
      ptr_q <= '0;
    else if (byteDone && phase_q == PH_ALO)
      ptr_q <= {addrHi_q, rxShift_q}; // R15
    else if (commit && cpConfig_q[AUTO_INC_BIT])
      ptr_q <= ptr_q + 16'd1; // R9 R11
    else if (state_q == ST_TXACK && sclRise && txLo_q && cpConfig_q[AUTO_INC_BIT])
      ptr_q <= ptr_q + 16'd1; // R9 R10 R11
  end

  // serial engine: byte framing, acknowledge and transmit
  always_ff @(posedge linkClk)
  begin
    if (!linkRstN)
    begin
      state_q <= ST_IDLE;
      phase_q <= PH_ID;
      bitCnt_q <= '0;
      rxShift_q <= '0;
      txShift_q <= '0;
      sdaOe_q <= 1'b0;
      isRead_q <= 1'b0;
      txLo_q <= 1'b0;
      addrHi_q <= '0;
      dataHi_q <= '0;
    end
    else if (stopCond)
    begin
      // stop, expected or not, always ends the frame
      state_q <= ST_IDLE; // R7 R8
      sdaOe_q <= 1'b0;
    end
    else if (startCond)
    begin
      // start or repeated start: expect an id byte
      state_q <= ST_RX; // R4 R8
      phase_q <= PH_ID;
      bitCnt_q <= '0;
      sdaOe_q <= 1'b0;
    end
    else
    begin
      unique case (state_q)
        ST_IDLE:
        begin
          sdaOe_q <= 1'b0; // R6
        end
        ST_RX:
        begin
          // sample on the rising edge, msb first
          if (sclRise && bitCnt_q != 4'd8)
          begin
            rxShift_q <= {rxShift_q[6:0], sdaS}; // R4
            bitCnt_q <= bitCnt_q + 4'd1;
          end
          else if (byteDone)
          begin
            state_q <= ST_RXACK;
            sdaOe_q <= 1'b1; // R5 R15
            if (phase_q == PH_ID)
            begin
              isRead_q <= rxShift_q[0]; // R3
              if (rxShift_q[7:1] != ownId[7:1])
              begin
                state_q <= ST_IDLE; // R6
                sdaOe_q <= 1'b0;
              end
            end
            if (phase_q == PH_AHI)
              addrHi_q <= rxShift_q;
            if (phase_q == PH_DHI)
              dataHi_q <= rxShift_q;
          end
        end
        ST_RXACK:
        begin
          // release after the ack pulse, or start sending
          if (sclFall)
          begin
            bitCnt_q <= '0;
            if (phase_q == PH_ID && isRead_q)
            begin
              state_q <= ST_TX; // R10
              txShift_q <= rdWord[15:8];
              sdaOe_q <= ~rdWord[15];
              txLo_q <= 1'b0;
            end
            else
            begin
              state_q <= ST_RX;
              sdaOe_q <= 1'b0;
              unique case (phase_q)
                PH_ID: phase_q <= PH_AHI;
                PH_AHI: phase_q <= PH_ALO;
                PH_ALO: phase_q <= PH_DHI;
                PH_DHI: phase_q <= PH_DLO;
                PH_DLO: phase_q <= PH_DHI; // R9
              endcase
            end
          end
        end
        ST_TX:
        begin
          // shift out on each falling edge, zero pulls low
          if (sclFall)
          begin
            if (bitCnt_q == 4'd7)
            begin
              state_q <= ST_TXACK;
              sdaOe_q <= 1'b0;
            end
            else
            begin
              txShift_q <= {txShift_q[6:0], 1'b0};
              sdaOe_q <= ~txShift_q[6]; // R1
              bitCnt_q <= bitCnt_q + 4'd1;
            end
          end
        end
        ST_TXACK:
        begin
          // master nack ends the read
          if (sclRise)
            state_q <= sdaS ? ST_IDLE : ST_TXNEXT; // R16
        end
        ST_TXNEXT:
        begin
          // after a low byte the index already stepped on the ack, so the next word is ready
          if (sclFall)
          begin
            state_q <= ST_TX;
            bitCnt_q <= '0;
            txLo_q <= ~txLo_q; // R15
            txShift_q <= txLo_q ? rdWord[15:8] : rdWord[7:0];
            sdaOe_q <= txLo_q ? ~rdWord[15] : ~rdWord[7];
          end
        end
        default:
        begin
          state_q <= ST_IDLE;
          sdaOe_q <= 1'b0;
        end
      endcase
    end
  end
endmodule

// ---- design/i2c_sync2.sv ----
// two flip-flop level synchroniser
// assumes d is a level that holds for several destination clocks
module i2c_sync2
(
  input wire logic clk,
  input wire logic d,
  output logic q
);
  logic meta_q; // first stage, read only by the second
  // no reset: the pair only ever carries a copy of d
  always_ff @(posedge clk)
  begin
    meta_q <= d;
    q <= meta_q;
  end
endmodule

// ---- verif/i2c_link_chk_sva.sv ----
// checker for the two-wire link between the bus master end and the register slave end
// assumes linkClk samples both lines many times per serial bit
module i2c_link_chk
(
  input wire logic linkClk,
  input wire logic rst_n,
  input wire logic scl,
  input wire logic sda,
  input wire logic sclOut,
  input wire logic hostSdaOut,
  input wire logic devSdaOut,
  input wire logic devSdaOe,
  input wire logic idSelect
);
  timeunit 1ns;
  timeprecision 100ps;
  import i2c_reg_pkg::*;
  logic sclPrev; // line levels one sample back
  logic sdaPrev;
  logic busy; // between start and stop
  logic matched; // last id byte was ours
  logic rdFrame; // last id byte asked to read
  logic ignored; // foreign id seen, waiting for a start
  logic [3:0] bitCnt; // clock rises within this byte
  logic [3:0] byteCnt; // bytes since the start
  logic [7:0] idByte; // id bits as they arrive
  logic sclRise;
  logic startSeen;
  logic stopSeen;
  logic idSlot;
  logic [7:0] ownId;
  assign sclRise = scl & ~sclPrev;
  assign startSeen = scl & sclPrev & sdaPrev & ~sda;
  assign stopSeen = scl & sclPrev & ~sdaPrev & sda;
  assign idSlot = sclRise && bitCnt == 4'h8 && byteCnt == 4'h0;
  assign ownId = idSelect ? ID_SEL_HIGH : ID_SEL_LOW;
  // line history for edge and condition detection
  always_ff @(posedge linkClk)
  begin
    sclPrev <= scl;
    sdaPrev <= sda;
  end
  // frame tracking; a start always restarts the count, even mid-byte
  always_ff @(posedge linkClk)
  begin
    if (!rst_n || startSeen)
    begin
      busy <= startSeen;
      ignored <= 1'b0;
      bitCnt <= 4'h0;
      byteCnt <= 4'h0;
    end
    else if (stopSeen)
      busy <= 1'b0;
    else if (sclRise && bitCnt == 4'h8)
    begin
      bitCnt <= 4'h0;
      byteCnt <= byteCnt + 4'h1;
      ignored <= idSlot && idByte[7:1] != ownId[7:1];
    end
    else if (sclRise)
      bitCnt <= bitCnt + 4'h1;
  end
  // id shift and the verdict taken at the id acknowledge slot
  always_ff @(posedge linkClk)
  begin
    if (sclRise && bitCnt != 4'h8 && byteCnt == 4'h0)
      idByte <= {idByte[6:0], sda};
    if (idSlot)
    begin
      matched <= idByte[7:1] == ownId[7:1];
      rdFrame <= idByte[0];
    end
  end
  default clocking cb @(posedge linkClk);
  endclocking
  default disable iff (!rst_n);
  sequence id_slot;
    sclRise && bitCnt == 4'h8 && byteCnt == 4'h0;
  endsequence
  sequence wr_data_slot;
    sclRise && bitCnt == 4'h8 && byteCnt != 4'h0 && matched && !rdFrame;
  endsequence
  sequence rd_data_slot;
    sclRise && bitCnt == 4'h8 && byteCnt != 4'h0 && matched && rdFrame;
  endsequence
  chk_dev_open_drain: assert property (devSdaOe |-> !devSdaOut)
    else $error("slave drives the data line high");
  chk_host_open_drain: assert property (!sclOut && !hostSdaOut)
    else $error("master drives a line high");
  chk_dev_hold_high: assert property (scl && $past(scl) |-> $stable(devSdaOe))
    else $error("slave moved the data line while the clock was high");
  chk_idle_quiet: assert property (!busy |-> !devSdaOe)
    else $error("slave drives the data line outside a frame");
  chk_id_ack: assert property (id_slot |-> devSdaOe == (idByte[7:1] == ownId[7:1]))
    else $error("id acknowledge does not follow the id match");
  chk_foreign_quiet: assert property (ignored |-> !devSdaOe)
    else $error("slave answers after a foreign id");
  chk_write_ack: assert property (wr_data_slot |-> devSdaOe)
    else $error("written byte not acknowledged");
  chk_read_release: assert property (rd_data_slot |-> !devSdaOe)
    else $error("slave holds the line in the master acknowledge slot");
endmodule

// ---- verif/i2c_register_slave_tb.sv ----
// self-checking bench: master end and slave end joined by one link
// assumes the package timing, so one register read takes some 11400 clocks
module i2c_register_slave_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import i2c_reg_pkg::*;
  logic clk = 1'b0; // 20 MHz core clock
  logic linkClk = 1'b0; // slave sampling clock, 125 ns
  logic rst_n = 1'b0;
  logic idSelect = 1'b0; // id-select pin level
  logic cmdValid = 1'b0;
  logic targetIdSel = 1'b0;
  host_cmd_t cmdKind = CMD_WRITE;
  logic [15:0] cmdAddr = 16'h0000;
  logic [15:0] cmdWData = 16'h0000;
  logic cmdReady;
  logic done;
  logic nackErr;
  logic [15:0] rdData;
  logic autoIncEn;
  logic idSelectPulldownEnable;
  int n_errors = 0;
  int n_tests = 0;
  int cycles = 0; // run length guard
  i2c_link_if link();
  i2c_reg_host_end i_i2c_reg_host_end (.clk(clk), .rst_n(rst_n), .link(link),
    .cmdValid(cmdValid), .cmdKind(cmdKind), .cmdAddr(cmdAddr), .cmdWData(cmdWData),
    .targetIdSel(targetIdSel), .cmdReady(cmdReady), .done(done), .nackErr(nackErr),
    .rdData(rdData));
  i2c_reg_slave_end i_i2c_reg_slave_end (.clk(clk), .rst_n(rst_n), .linkClk(linkClk),
    .link(link), .idSelect(idSelect), .autoIncEn(autoIncEn),
    .idSelectPulldownEnable(idSelectPulldownEnable));
  i2c_link_chk i_i2c_link_chk (.linkClk(linkClk), .rst_n(rst_n), .scl(link.scl),
    .sda(link.sda), .sclOut(link.sclOut), .hostSdaOut(link.hostSdaOut),
    .devSdaOut(link.devSdaOut), .devSdaOe(link.devSdaOe), .idSelect(idSelect));
  // clocks; the link clock starts off phase so edges never line up
  always #25 clk = ~clk;
  initial
  begin
    #17;
    forever #62.5 linkClk = ~linkClk;
  end
  // verdict and end of run
  task automatic complete_run();
    if (n_errors == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // one comparison, four-state exact
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      n_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one master command, from taking edge to the done pulse
  task automatic run(input host_cmd_t k, input logic [15:0] a, input logic [15:0] w,
    input logic s);
    int n;
    n = 0;
    while (cmdReady !== 1'b1 && n < 20000)
    begin
      @(negedge clk);
      n++;
    end
    // a master that never comes back to idle is a failure too
    if (n >= 20000)
      n_errors++;
    cmdKind = k;
    cmdAddr = a;
    cmdWData = w;
    targetIdSel = s;
    cmdValid = 1'b1;
    @(negedge clk);
    cmdValid = 1'b0;
    n = 0;
    while (done !== 1'b1 && n < 20000)
    begin
      @(negedge clk);
      n++;
    end
    if (n >= 20000)
      n_errors++;
    @(negedge clk);
  endtask
  // hang guard, well above the expected 90000 clocks
  always @(posedge clk)
  begin
    cycles = cycles + 1;
    if (cycles == 100000)
    begin
      n_errors = n_errors + 1;
      complete_run();
    end
  end
  // main sequence
  initial
  begin
    repeat (20) @(negedge clk);
    check({15'h0000, autoIncEn}, 16'h0001);
    check({15'h0000, idSelectPulldownEnable}, 16'h0001);
    rst_n = 1'b1;
    repeat (30) @(negedge clk);
    check({14'h0000, link.scl, link.sda}, 16'h0003);
    run(CMD_READ, REG_CP_CONFIG, 16'h0000, 1'b0);
    check(rdData, CP_CONFIG_RST);
    check({14'h0000, cmdReady, done}, 16'h0002);
    run(CMD_READ, 16'h0720, 16'h0000, 1'b0);
    check(rdData, 16'h0000);
    // the index stepped past the low byte, so this lands on 0721h
    run(CMD_READ_LAST, 16'h0000, 16'h0000, 1'b0);
    check(rdData, PULL_CTRL_RST);
    run(CMD_WRITE, REG_PULL_CTRL, 16'h0000, 1'b0);
    check({15'h0000, idSelectPulldownEnable}, 16'h0000);
    run(CMD_READ, REG_PULL_CTRL, 16'h0000, 1'b0);
    check(rdData, 16'h0000);
    run(CMD_WRITE, REG_CP_CONFIG, 16'h0000, 1'b0);
    repeat (10) @(negedge clk);
    check({15'h0000, autoIncEn}, 16'h0000);
    run(CMD_READ, REG_ID, 16'h0000, 1'b0);
    check(rdData, DEVICE_ID_WORD);
    check({15'h0000, nackErr}, 16'h0000);
    // stepping is off now, so the index must still point at the id word
    run(CMD_READ_LAST, 16'h0000, 16'h0000, 1'b0);
    check(rdData, DEVICE_ID_WORD);
    // move the slave to the high id; the old id must now be refused
    idSelect = 1'b1;
    repeat (10) @(negedge clk);
    run(CMD_READ, REG_STATUS, 16'h0000, 1'b0);
    check({15'h0000, nackErr}, 16'h0001);
    run(CMD_READ, REG_STATUS, 16'h0000, 1'b1);
    check({14'h0000, nackErr, rdData[CORE_ALIVE_BIT]}, 16'h0001);
    check({14'h0000, link.scl, link.sda}, 16'h0003);
    complete_run();
  end
endmodule
